//--- core/uv_fault_response.sv
// Output under-voltage fault response controller with its config bytes.
//
// What this block does
// RULE_01 - Response 00b ignores the fault and leaves the output running.
// RULE_02 - Response 01b runs on for the delay, then retries if still faulty.
// RULE_03 - Response 10b disables the output at once and then retries.
// RULE_04 - Response 11b holds the output off only while the fault lasts.
// RULE_05 - The restart count equals the 3-bit retries field, for values below 111b.
// RULE_06 - Retries 000 means no restart; stay off until the fault is cleared.
// RULE_07 - Retries 111b means restarting without any limit.
// RULE_08 - Retries 1 to 6 give that many attempts, then stay off latched.
// RULE_09 - Restart starts are spaced by the decoded delay field times the unit.
// RULE_10 - Status clear, clear-faults, reset, off-then-on or power loss clear.
// RULE_11 - The delay field n decodes to 2 to the n units.
// RULE_12 - One unit's length comes from the time-unit byte at code 0xD2.
// RULE_13 - Endless retrying stops on off command, power loss or other fault.
// RULE_14 - A fault exists while measured output is under the fault limit.
`timescale 1ns/10ps
module uv_fault_response
    import uv_fault_pkg::*;
#(
    parameter int UNIT_CYCLES = UNIT_STEP_CYCLES
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire mgmt_cmd_t cmd,
    input wire logic [15:0] vout_sample,
    input wire logic [15:0] uv_fault_limit,
    input wire logic output_on_pin,
    input wire logic status_clear,
    input wire logic other_fault,
    output logic [7:0] read_data,
    output logic output_enable,
    output logic uv_fault_flag,
    output logic retrying
);

    uv_action_t action;
    uv_action_t next_action;
    logic [7:0] time_unit;
    logic [7:0] next_time_unit;
    logic [7:0] next_read_data;
    uv_state_t state;
    uv_state_t next_state;
    logic [2:0] attempts;
    logic [2:0] next_attempts;
    logic next_output_enable;
    logic next_fault_flag;
    logic next_retrying;
    logic on_meta;
    logic on_sync;
    logic on_prev;
    logic uv_now;
    logic clear_event;
    logic timer_load;
    logic timer_done;
    logic [TIMER_WIDTH-1:0] unit_span;
    logic [TIMER_WIDTH-1:0] span;
    logic may_retry;

    // Control pin arrives asynchronously; only on_sync and on_prev are ever read.
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            on_meta <= 1'b0;
            on_sync <= 1'b0;
            on_prev <= 1'b0;
        end
        else
        begin
            on_meta <= output_on_pin;
            on_sync <= on_meta;
            on_prev <= on_sync;
        end
    end

    assign uv_now = (vout_sample < uv_fault_limit); // RULE_14

    // Reset and bias loss act through rstn; the rest are pulses here.
    assign clear_event = status_clear | (on_sync & ~on_prev)
                         | (cmd.valid & cmd.write
                            & (cmd.code == CODE_CLEAR_FAULTS)); // RULE_10

    // One unit in cycles, then scaled by 2 to the delay field.
    assign unit_span = TIMER_WIDTH'(({1'b0, time_unit} + 9'h001)
                                    * UNIT_CYCLES); // RULE_12
    assign span = unit_span << action.delay; // RULE_11

    assign may_retry = (action.retries == RETRY_FOREVER)
                       || (attempts < action.retries); // RULE_05

    interval_timer #(.WIDTH(TIMER_WIDTH)) spacing_timer
    (
        .clock(clock),
        .rstn(rstn),
        .load(timer_load),
        .span(span),
        .done(timer_done)
    );

    always_comb
    begin
        next_action = action;
        next_time_unit = time_unit;
        next_read_data = read_data;
        if (cmd.valid && cmd.write && cmd.code == CODE_UV_ACTION)
        begin
            next_action = uv_action_t'(cmd.data);
        end
        if (cmd.valid && cmd.write && cmd.code == CODE_TIME_UNIT)
        begin
            next_time_unit = cmd.data;
        end
        if (cmd.valid && !cmd.write)
        begin
            unique case (cmd.code)
                CODE_UV_ACTION: next_read_data = action;
                CODE_TIME_UNIT: next_read_data = time_unit;
                default: next_read_data = READ_UNMAPPED;
            endcase
        end
    end

    always_comb
    begin
        next_state = state;
        next_attempts = attempts;
        timer_load = 1'b0;
        if (!on_sync || other_fault)
        begin
            // Off or another fault ends any retry sequence.
            next_state = on_sync ? ST_LATCHED : ST_RUN; // RULE_13
            next_attempts = '0;
        end
        else
        begin
            unique case (state)
                ST_RUN:
                begin
                    if (uv_now)
                    begin
                        unique case (action.response)
                            RESP_IGNORE: next_state = ST_RUN; // RULE_01
                            RESP_DELAY_THEN_RETRY:
                            begin
                                next_state = ST_DELAY; // RULE_02
                                timer_load = 1'b1;
                            end
                            RESP_DISABLE_RETRY:
                            begin
                                next_state = ST_OFF_WAIT; // RULE_03
                                timer_load = 1'b1;
                            end
                            RESP_DISABLE_WHILE: next_state = ST_HOLD; // RULE_04
                        endcase
                    end
                end
                ST_DELAY:
                begin
                    if (timer_done)
                    begin
                        next_state = uv_now ? ST_OFF_WAIT : ST_RUN; // RULE_02
                        timer_load = uv_now;
                    end
                end
                ST_OFF_WAIT:
                begin
                    if (clear_event)
                    begin
                        next_state = ST_RUN;
                        next_attempts = '0;
                    end
                    else if (timer_done && may_retry)
                    begin
                        next_state = ST_RESTART; // RULE_07
                        timer_load = 1'b1; // RULE_09
                        if (action.retries != RETRY_FOREVER)
                        begin
                            next_attempts = attempts + 3'h1;
                        end
                    end
                    else if (timer_done)
                    begin
                        next_state = ST_LATCHED; // RULE_06
                    end
                end
                ST_RESTART:
                begin
                    // A failed attempt goes off but keeps the same spacing.
                    // One that fails on its last cycle reloads the timer,
                    // since the off wait would otherwise never expire.
                    if (uv_now)
                    begin
                        next_state = ST_OFF_WAIT;
                        timer_load = timer_done; // RULE_09
                    end
                    else if (timer_done)
                    begin
                        next_state = ST_RUN;
                        next_attempts = '0;
                    end
                end
                ST_LATCHED:
                begin
                    if (clear_event)
                    begin
                        next_state = ST_RUN; // RULE_10
                        next_attempts = '0;
                    end
                end
                ST_HOLD:
                begin
                    if (!uv_now)
                    begin
                        next_state = ST_RUN; // RULE_04
                    end
                end
                default: next_state = ST_LATCHED;
            endcase
        end
        next_output_enable = on_sync && (next_state == ST_RUN
                                         || next_state == ST_DELAY
                                         || next_state == ST_RESTART);
        next_retrying = (next_state == ST_OFF_WAIT
                         || next_state == ST_RESTART);
        // A new fault in the clear cycle still sets the flag.
        next_fault_flag = (uv_now && on_sync
                           && action.response != RESP_IGNORE)
                          || (uv_fault_flag && !clear_event);
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            action <= uv_action_t'(UV_ACTION_RESET);
            time_unit <= TIME_UNIT_RESET;
            read_data <= READ_UNMAPPED;
            state <= ST_RUN;
            attempts <= '0;
            output_enable <= 1'b0;
            uv_fault_flag <= 1'b0;
            retrying <= 1'b0;
        end
        else
        begin
            action <= next_action;
            time_unit <= next_time_unit;
            read_data <= next_read_data;
            state <= next_state;
            attempts <= next_attempts;
            output_enable <= next_output_enable;
            uv_fault_flag <= next_fault_flag;
            retrying <= next_retrying;
        end
    end

    // Helper: cycles since the last timer load and the span it loaded.
    logic [TIMER_WIDTH-1:0] since_load;
    logic [TIMER_WIDTH-1:0] loaded_span;
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            since_load <= '0;
            loaded_span <= '0;
        end
        else
        begin
            since_load <= timer_load ? TIMER_WIDTH'(1)
                                     : since_load + TIMER_WIDTH'(1);
            loaded_span <= timer_load ? span : loaded_span;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence steady_on;
        on_sync && !other_fault;
    endsequence

    sequence wait_expires;
        steady_on and (state == ST_OFF_WAIT && timer_done && !clear_event);
    endsequence

    ignore_keeps_on_a: assert property ( // RULE_01
        steady_on and (state == ST_RUN && uv_now
                       && action.response == RESP_IGNORE)
        |=> state == ST_RUN && output_enable)
        else $error("ignored fault disturbed the output");

    delay_runs_on_a: assert property ( // RULE_02
        state == ST_DELAY |-> output_enable)
        else $error("output dropped during fault delay");

    disable_now_a: assert property ( // RULE_03
        steady_on and (state == ST_RUN && uv_now
                       && action.response == RESP_DISABLE_RETRY)
        |=> !output_enable && state == ST_OFF_WAIT)
        else $error("output not disabled at once");

    hold_resume_a: assert property ( // RULE_04
        steady_on and (state == ST_HOLD && !uv_now)
        |=> state == ST_RUN && output_enable)
        else $error("output did not resume after fault left");

    no_retry_a: assert property ( // RULE_06
        wait_expires and (action.retries == RETRY_NONE)
        |=> state == ST_LATCHED && !output_enable)
        else $error("restart attempted with retries zero");

    attempt_limit_a: assert property ( // RULE_08
        wait_expires and (action.retries != RETRY_FOREVER
                          && attempts >= action.retries)
        |=> state == ST_LATCHED)
        else $error("restart beyond the programmed count");

    forever_retry_a: assert property ( // RULE_07
        wait_expires and (action.retries == RETRY_FOREVER)
        |=> state == ST_RESTART ##1 attempts == $past(attempts, 2))
        else $error("continuous retry stopped or counted");

    spacing_exact_a: assert property ( // RULE_09
        timer_done |-> since_load == loaded_span)
        else $error("restart spacing differs from programmed span");

    latch_clear_a: assert property ( // RULE_10
        steady_on and (state == ST_LATCHED && clear_event)
        |=> state == ST_RUN)
        else $error("latched fault not cleared");

    off_stops_a: assert property ( // RULE_13
        !on_sync |=> !output_enable && !retrying)
        else $error("output or retry alive while commanded off");

    flag_cause_a: assert property ( // RULE_14
        $rose(uv_fault_flag) |-> $past(uv_now))
        else $error("fault flag set without under-voltage");

endmodule

//--- core/uv_fault_pkg.sv
// Shared constants and types for the output under-voltage fault response.
package uv_fault_pkg;

    // Management command codes.
    localparam logic [7:0] CODE_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CODE_UV_ACTION = 8'h45;
    localparam logic [7:0] CODE_TIME_UNIT = 8'hd2;

    // Reset values of the two configuration bytes, and the byte read back from unmapped codes.
    localparam logic [7:0] UV_ACTION_RESET = 8'h00;
    localparam logic [7:0] TIME_UNIT_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // One time-unit step is one microsecond; the unit register adds steps.
    localparam int CLOCK_PERIOD_NS = 8;
    localparam int UNIT_STEP_NS = 1000;
    localparam int UNIT_STEP_CYCLES = (UNIT_STEP_NS + CLOCK_PERIOD_NS - 1)
                                      / CLOCK_PERIOD_NS;

    // Widest interval: 256 steps times 128 units times 125 cycles.
    localparam int TIMER_WIDTH = 24;

    typedef enum logic [1:0]
    {
        RESP_IGNORE = 2'h0,
        RESP_DELAY_THEN_RETRY = 2'h1,
        RESP_DISABLE_RETRY = 2'h2,
        RESP_DISABLE_WHILE = 2'h3
    } response_t;

    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    // Field layout of the fault action byte, most significant field first.
    typedef struct packed
    {
        response_t response;
        logic [2:0] retries;
        logic [2:0] delay;
    } uv_action_t;

    // One management transaction as delivered by the protocol decoder.
    typedef struct packed
    {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [7:0] data;
    } mgmt_cmd_t;

    typedef enum logic [2:0]
    {
        ST_RUN = 3'h0,
        ST_DELAY = 3'h1,
        ST_OFF_WAIT = 3'h3,
        ST_RESTART = 3'h2,
        ST_LATCHED = 3'h6,
        ST_HOLD = 3'h7
    } uv_state_t;

endpackage

//--- core/interval_timer.sv
// Down-counting interval timer that pulses once when a loaded span ends.
`timescale 1ns/10ps
module interval_timer
#(
    parameter int WIDTH = 24
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic load,
    input wire logic [WIDTH-1:0] span,
    output logic done
);

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic next_done;

    // A span of N gives done exactly N cycles after the load cycle.
    always_comb
    begin
        next_count = count;
        next_done = 1'b0;
        if (load)
        begin
            // A one-cycle span has no count to run down, so it fires at once.
            next_count = span - WIDTH'(1);
            next_done = (span == WIDTH'(1));
        end
        else if (count != '0)
        begin
            next_count = count - WIDTH'(1);
            next_done = (count == WIDTH'(1));
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            count <= '0;
            done <= 1'b0;
        end
        else
        begin
            count <= next_count;
            done <= next_done;
        end
    end

endmodule

//--- verification/pmbus_host.sv
// Management host model that issues byte commands to the fault block.
`timescale 1ns/10ps
module pmbus_host
    import uv_fault_pkg::*;
(
    input wire logic clock,
    input wire logic [7:0] read_data,
    output mgmt_cmd_t cmd
);
    initial cmd = '0;

    // Each command stands for exactly one rising edge, so none is taken twice.
    task automatic send(input logic wr, input logic [7:0] c,
                        input logic [7:0] d);
        @(negedge clock);
        cmd = '{valid: 1'b1, write: wr, code: c, data: d};
        @(negedge clock);
        cmd = '0;
    endtask

    task automatic write_byte(input logic [7:0] c, input logic [7:0] d);
        send(1'b1, c, d);
    endtask

    task automatic clear_faults();
        send(1'b1, CODE_CLEAR_FAULTS, 8'h00);
    endtask

    // The answer is registered on the edge that takes the read, so it has
    // settled by the falling edge on which send returns.
    task automatic read_byte(input logic [7:0] c, output logic [7:0] d);
        send(1'b0, c, 8'h00);
        d = read_data;
    endtask
endmodule

//--- verification/testbench.sv
// Self-checking bench for the under-voltage fault response block.
`timescale 1ns/10ps
module testbench
    import uv_fault_pkg::*;
;
    localparam int UNIT = 2;
    localparam int LIMIT = 20000;
    typedef struct {logic [7:0] act; logic [7:0] unit; int rises;} row_t;
    row_t rows [7] = '{'{8'h88, 8'h00, 1}, '{8'h91, 8'h00, 2},
        '{8'h9a, 8'h01, 3}, '{8'ha3, 8'h00, 4}, '{8'hac, 8'h00, 5},
        '{8'hb5, 8'h02, 6}, '{8'h86, 8'h00, 0}};
    logic clock = 1'b0;
    logic rstn = 1'b0;
    mgmt_cmd_t cmd;
    logic [15:0] vout_sample = 16'h0200;
    logic [15:0] uv_fault_limit = 16'h0200;
    logic output_on_pin = 1'b0;
    logic status_clear = 1'b0;
    logic other_fault = 1'b0;
    logic [7:0] read_data;
    logic output_enable;
    logic uv_fault_flag;
    logic retrying;
    logic [7:0] rd;
    int num_errors = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    int r;
    int span;

    uv_fault_response #(.UNIT_CYCLES(UNIT)) uut (.clock(clock), .rstn(rstn),
        .cmd(cmd), .vout_sample(vout_sample),
        .uv_fault_limit(uv_fault_limit), .output_on_pin(output_on_pin),
        .status_clear(status_clear), .other_fault(other_fault),
        .read_data(read_data), .output_enable(output_enable),
        .uv_fault_flag(uv_fault_flag), .retrying(retrying));
    pmbus_host host (.clock(clock), .read_data(read_data), .cmd(cmd));

    always #4 clock = ~clock;

    always @(posedge clock)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (num_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check_bit(logic got, logic exp, string what);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    task automatic check_byte(logic [7:0] got, logic [7:0] exp, string what);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    task automatic check_count(int got, int lo, int hi, string what);
        checks++;
        if (got < lo || got > hi)
        begin
            num_errors++;
            $display("unexpected at %0t: %s %0d", $time, what, got);
        end
    endtask

    // A healthy sample sits exactly on the limit, the faulty one just below.
    task automatic set_fault(logic on);
        @(negedge clock);
        vout_sample = on ? 16'h01ff : 16'h0200;
    endtask

    task automatic wait_oe(logic v, int max, output int k);
        k = 0;
        do
        begin
            @(posedge clock);
            #1;
            k++;
        end while (output_enable !== v && k < max);
    endtask

    task automatic count_rises(int w, output int k);
        logic prev;
        k = 0;
        prev = output_enable;
        repeat (w)
        begin
            @(posedge clock);
            #1;
            if (output_enable === 1'b1 && prev !== 1'b1)
                k++;
            prev = output_enable;
        end
    endtask

    task automatic clear_all();
        set_fault(1'b0);
        @(negedge clock);
        status_clear = 1'b1;
        @(negedge clock);
        status_clear = 1'b0;
        repeat (4) @(negedge clock);
        check_bit(output_enable, 1'b1, "output back on");
        check_bit(uv_fault_flag, 1'b0, "flag cleared");
    endtask

    initial
    begin
        repeat (5) @(negedge clock);
        rstn = 1'b1;
        host.read_byte(CODE_UV_ACTION, rd);
        check_byte(rd, 8'h00, "action reset");
        host.read_byte(CODE_TIME_UNIT, rd);
        check_byte(rd, 8'h00, "unit reset");
        host.write_byte(8'h10, 8'hff);
        host.read_byte(8'h10, rd);
        check_byte(rd, 8'h00, "unmapped read");
        output_on_pin = 1'b1;
        repeat (5) @(negedge clock);
        check_bit(output_enable, 1'b1, "output on");
        foreach (rows[i])
        begin
            host.write_byte(CODE_UV_ACTION, rows[i].act);
            host.write_byte(CODE_TIME_UNIT, rows[i].unit);
            host.read_byte(CODE_UV_ACTION, rd);
            check_byte(rd, rows[i].act, "action readback");
            span = (rows[i].unit + 1) * UNIT * (1 << rows[i].act[2:0]);
            set_fault(1'b1);
            wait_oe(1'b0, 4, n);
            check_count(n, 1, 2, "shutdown delay");
            check_bit(uv_fault_flag, 1'b1, "flag set");
            r = 0;
            if (rows[i].rises > 0)
            begin
                wait_oe(1'b1, span + 2, n);
                check_count(n, span, span, "restart spacing");
                count_rises(rows[i].rises * span + 8, r);
                r++;
            end
            else
                count_rises(2 * span + 8, r);
            check_count(r, rows[i].rises, rows[i].rises, "restarts");
            check_bit(output_enable, 1'b0, "latched off");
            check_bit(retrying, 1'b0, "retry ended");
            clear_all();
        end
        host.write_byte(CODE_UV_ACTION, 8'h3f);
        set_fault(1'b1);
        wait_oe(1'b0, 40, n);
        check_count(n, 40, 40, "ignored fault");
        check_bit(uv_fault_flag, 1'b0, "no flag");
        set_fault(1'b0);
        host.write_byte(CODE_UV_ACTION, 8'hc0);
        set_fault(1'b1);
        wait_oe(1'b0, 4, n);
        check_count(n, 1, 2, "off while fault");
        set_fault(1'b0);
        wait_oe(1'b1, 4, n);
        check_count(n, 1, 2, "on after fault");
        host.write_byte(CODE_UV_ACTION, 8'h42);
        set_fault(1'b1);
        set_fault(1'b0);
        wait_oe(1'b0, 20, n);
        check_count(n, 20, 20, "short fault rides");
        host.write_byte(CODE_UV_ACTION, 8'h47);
        set_fault(1'b1);
        wait_oe(1'b0, 300, n);
        check_count(n, 256, 258, "run-on delay");
        wait_oe(1'b1, 20, n);
        check_count(n, 20, 20, "stays off");
        set_fault(1'b0);
        host.clear_faults();
        repeat (3) @(negedge clock);
        check_bit(output_enable, 1'b1, "clear command");
        host.write_byte(CODE_UV_ACTION, 8'hb8);
        set_fault(1'b1);
        count_rises(80, r);
        check_count(r, 8, 80, "endless restarts");
        check_bit(retrying, 1'b1, "retrying");
        @(negedge clock);
        other_fault = 1'b1;
        repeat (4) @(negedge clock);
        count_rises(40, r);
        check_count(r, 0, 0, "stopped by other fault");
        check_bit(retrying, 1'b0, "retry stopped");
        set_fault(1'b0);
        other_fault = 1'b0;
        output_on_pin = 1'b0;
        repeat (5) @(negedge clock);
        check_bit(output_enable, 1'b0, "commanded off");
        output_on_pin = 1'b1;
        repeat (6) @(negedge clock);
        check_bit(output_enable, 1'b1, "off then on");
        check_bit(uv_fault_flag, 1'b0, "off then on flag");
        host.write_byte(CODE_UV_ACTION, 8'h80);
        set_fault(1'b1);
        set_fault(1'b0);
        repeat (3) @(negedge clock);
        check_bit(uv_fault_flag, 1'b1, "latched");
        rstn = 1'b0;
        repeat (5) @(negedge clock);
        rstn = 1'b1;
        repeat (5) @(negedge clock);
        check_bit(uv_fault_flag, 1'b0, "reset clears");
        check_bit(output_enable, 1'b1, "on after reset");
        host.read_byte(CODE_UV_ACTION, rd);
        check_byte(rd, 8'h00, "action after reset");
        tally_and_finish();
    end
endmodule
